// ---- sfr_defines.svh ----
// register offsets, field positions and reset values of the special-function bank
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH
`define SFR_STATUS_OFS    4'h3
`define SFR_BANK_OFS      4'h4
`define SFR_PORT5_OFS     4'h5
`define SFR_BROWNOUT_OFS  4'h6
`define SFR_MISC_OFS      4'h7
`define SFR_ANALOG_OFS    4'h8
`define ST_TIMEOUT_BIT    4
`define ST_PWRDN_BIT      3
`define ST_ZERO_BIT       2
`define ST_HCARRY_BIT     1
`define ST_CARRY_BIT      0
`define BO_IRQ_FLAG_BIT   6
`define BO_STATE_N_BIT    5
`define BO_IRQ_EN_BIT     4
`define BO_WAKE_EN_BIT    3
`define BO_DET_ON_BIT     2
`define MISC_IRQ_PIN_BIT  2
`define STATUS_RST        8'h18
`define BANK_RST          8'h00
`define PORT5_RST         8'h00
`define BROWNOUT_RST      8'h00
`define MISC_RST          8'h20
`define ANALOG_RST        8'h00
`define BANK_WMASK        8'h7f
`define BROWNOUT_WMASK    8'h1f
`define MISC_WMASK        8'h3f
`define ANALOG_WMASK      8'h7f
`endif

// ---- sfr_pkg.sv ----
// types shared by the special-function register bank
package sfr_pkg;
    typedef enum logic [1:0] {
        LVL_4V5,
        LVL_4V0,
        LVL_3V3,
        LVL_2V2
    } bo_level_t;
    typedef struct packed {
        logic       core_osc_select;
        logic       idle_on_sleep;
        logic       ext_irq_pin_sel;
        logic       tick_counter_clk_sel;
        logic       timer1_clk_sel;
        logic       timer2_clk_sel;
    } misc_ctrl_t;
    typedef struct packed {
        logic       sleep_instr;
        logic       watchdog_clear_instr;
        logic       watchdog_timeout;
        logic       irq_global_on_instr;
        logic       irq_global_off_instr;
    } core_events_t;
    typedef struct packed {
        logic       zero;
        logic       half_carry_flag;
        logic       carry;
    } alu_flags_t;
endpackage : sfr_pkg

// ---- mcu_special_function_regs.sv ----
// special-function register bank: status, bank select, port 5, brownout, misc and analog select
`timescale 1ns/100ps
`include "sfr_defines.svh"
module mcu_special_function_regs #(
    parameter int PORT_W = 8
) (
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 clk_en_i,
    input  wire logic [3:0]           addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [7:0]           rdata_o,
    input  wire sfr_pkg::core_events_t events_i,
    input  wire logic                 alu_update_i,
    input  wire sfr_pkg::alu_flags_t  alu_flags_i,
    input  wire logic                 below_level_i,
    input  wire logic [PORT_W-1:0]    port5_pins_i,
    input  wire logic [PORT_W-1:0]    port5_dir_i,
    output logic      [PORT_W-1:0]    port5_out_o,
    output logic      [PORT_W-1:0]    port5_oe_o,
    output logic      [6:0]           analog_en_o,
    output logic      [5:0]           indirect_addr_o,
    output logic                      data_bank_o,
    output sfr_pkg::bo_level_t        brownout_level_sel_o,
    output logic                      brownout_detector_on_o,
    output sfr_pkg::misc_ctrl_t       misc_ctrl_o,
    output logic                      main_osc_run_o,
    output logic                      enter_idle_o,
    output logic                      enter_sleep_o,
    output logic                      brownout_irq_o,
    output logic                      ext_irq_o,
    output logic                      brownout_wake_o,
    output logic                      irq_global_o
);
    logic [7:0]        status_q;
    logic [7:0]        bank_q;
    logic [PORT_W-1:0] port5_q;
    logic [4:0]        bo_ctrl_q;
    logic              bo_flag_q;
    logic [5:0]        misc_q;
    logic [6:0]        analog_q;
    logic              gie_q;
    logic [PORT_W-1:0] pin_s1_q;
    logic [PORT_W-1:0] pin_s2_q;
    logic [PORT_W-1:0] pin_s3_q;
    logic [PORT_W-1:0] pin_q;
    logic              low_s1_q;
    logic              low_s2_q;
    logic              low_s3_q;
    logic              low_q;
    logic              low_prev_q;
    logic [7:0]        rdata_q;
    logic              state_n;
    logic              detect_ev;

    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] ofs);
        wr_hit = wr_i && clk_en_i && (a == ofs);
    endfunction : wr_hit

    // three-stage synchronisers; a change counts when stages two and three agree
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_q    <= '0;
            low_s1_q <= 1'b0;
            low_s2_q <= 1'b0;
            low_s3_q <= 1'b0;
            low_q    <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pin_s1_q <= port5_pins_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int i = 0; i < PORT_W; i++)
            begin
                if (pin_s2_q[i] == pin_s3_q[i])
                    pin_q[i] <= pin_s3_q[i];
            end
            low_s1_q <= below_level_i;
            low_s2_q <= low_s1_q;
            low_s3_q <= low_s2_q;
            if (low_s2_q == low_s3_q)
                low_q <= low_s3_q;
        end
    end

    assign state_n   = !(bo_ctrl_q[`BO_DET_ON_BIT] && low_q);
    assign detect_ev = bo_ctrl_q[`BO_DET_ON_BIT] && low_q && !low_prev_q;

    // status: sleep/watchdog events own T and P; software cannot touch them
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            status_q <= `STATUS_RST;
        else if (clk_en_i)
        begin
            if (wr_hit(addr_i, `SFR_STATUS_OFS))
            begin
                status_q[7:5] <= wdata_i[7:5] & 3'b010;
                status_q[2:0] <= wdata_i[2:0];
            end
            if (alu_update_i)
                status_q[2:0] <= {alu_flags_i.zero, alu_flags_i.half_carry_flag,
                                  alu_flags_i.carry};
            if (events_i.watchdog_timeout)
                status_q[`ST_TIMEOUT_BIT] <= 1'b0;
            if (events_i.sleep_instr || events_i.watchdog_clear_instr)
                status_q[`ST_TIMEOUT_BIT] <= 1'b1;
            if (events_i.sleep_instr)
                status_q[`ST_PWRDN_BIT] <= 1'b0;
            if (events_i.watchdog_clear_instr)
                status_q[`ST_PWRDN_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            bank_q   <= `BANK_RST;
            port5_q  <= PORT_W'(`PORT5_RST);
            misc_q   <= 6'(`MISC_RST);
            analog_q <= 7'(`ANALOG_RST);
        end
        else if (clk_en_i)
        begin
            if (wr_hit(addr_i, `SFR_BANK_OFS))
                bank_q <= wdata_i & `BANK_WMASK;
            if (wr_hit(addr_i, `SFR_PORT5_OFS))
                port5_q <= wdata_i[PORT_W-1:0];
            if (wr_hit(addr_i, `SFR_MISC_OFS))
                misc_q <= wdata_i[5:0];
            if (wr_hit(addr_i, `SFR_ANALOG_OFS))
                analog_q <= wdata_i[6:0];
        end
    end

    // brownout: detection set wins over a software clear in the same cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            bo_ctrl_q  <= 5'h00;
            bo_flag_q  <= 1'b0;
            low_prev_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            low_prev_q <= bo_ctrl_q[`BO_DET_ON_BIT] && low_q;
            if (wr_hit(addr_i, `SFR_BROWNOUT_OFS))
            begin
                bo_ctrl_q <= wdata_i[4:0];
                if (!wdata_i[`BO_IRQ_FLAG_BIT])
                    bo_flag_q <= 1'b0;
            end
            if (detect_ev)
                bo_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            gie_q <= 1'b0;
        else if (clk_en_i)
        begin
            if (events_i.irq_global_off_instr)
                gie_q <= 1'b0;
            else if (events_i.irq_global_on_instr)
                gie_q <= 1'b1;
        end
    end

    // read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_q <= 8'h00;
        else if (clk_en_i)
        begin
            rdata_q <= 8'h00;
            if (rd_i)
            begin
                case (addr_i)
                    `SFR_STATUS_OFS:   rdata_q <= status_q;
                    `SFR_BANK_OFS:     rdata_q <= bank_q;
                    `SFR_PORT5_OFS:
                    begin
                        for (int i = 0; i < PORT_W; i++)
                            rdata_q[i] <= port5_dir_i[i] ? pin_q[i] : port5_q[i];
                    end
                    `SFR_BROWNOUT_OFS: rdata_q <= {1'b0, bo_flag_q, state_n, bo_ctrl_q};
                    `SFR_MISC_OFS:     rdata_q <= {2'b00, misc_q};
                    `SFR_ANALOG_OFS:   rdata_q <= {1'b0, analog_q};
                    default:           rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign rdata_o                = rdata_q;
    assign indirect_addr_o        = bank_q[5:0];
    assign data_bank_o            = bank_q[6];
    assign port5_out_o            = port5_q;
    // pins set as input or switched to analog never drive; the irq pin is kept an input while misc_q[3] selects it
    always_comb
    begin
        port5_oe_o = ~port5_dir_i & ~PORT_W'(analog_q);
        if (misc_q[3])
            port5_oe_o[2] = 1'b0;
    end
    assign analog_en_o            = analog_q;
    assign brownout_level_sel_o   = sfr_pkg::bo_level_t'(bo_ctrl_q[1:0]);
    assign brownout_detector_on_o = bo_ctrl_q[`BO_DET_ON_BIT];
    assign misc_ctrl_o            = misc_q;
    assign main_osc_run_o         = misc_q[5];
    assign enter_idle_o           = events_i.sleep_instr && misc_q[4];
    assign enter_sleep_o          = events_i.sleep_instr && !misc_q[4];
    assign brownout_irq_o         = gie_q && bo_ctrl_q[`BO_IRQ_EN_BIT] && bo_flag_q;
    // active-low pin, masked while the select is clear
    assign ext_irq_o              = gie_q && misc_q[3] && !pin_q[2];
    assign brownout_wake_o        = bo_ctrl_q[`BO_WAKE_EN_BIT] && bo_flag_q;
    assign irq_global_o           = gie_q;

    property p_timeout_after_sleep;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && events_i.sleep_instr && !events_i.watchdog_clear_instr)
            |=> (status_q[4] && !status_q[3]);
    endproperty
    a_timeout_after_sleep: assert property (p_timeout_after_sleep)
        else $error("sleep did not set timeout and clear power-down");

    property p_wdt_clear;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && events_i.watchdog_clear_instr && !events_i.sleep_instr)
            |=> (status_q[4] && status_q[3]);
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog clear did not set both flags");

    property p_tp_readonly;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && wr_i && addr_i == 4'h3 && events_i == '0)
            |=> $stable(status_q[4:3]);
    endproperty
    a_tp_readonly: assert property (p_tp_readonly)
        else $error("software write changed timeout or power-down");

    property p_flag_set;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && detect_ev) |=> bo_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("detection did not set brownout flag");

    property p_state_off;
        @(posedge clk_i) disable iff (!nrst_i)
        !bo_ctrl_q[2] |-> state_n;
    endproperty
    a_state_off: assert property (p_state_off)
        else $error("state bit low while detector off");

    property p_brown_read;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && rd_i && addr_i == 4'h6) |=> (rdata_o[7] == 1'b0);
    endproperty
    a_brown_read: assert property (p_brown_read)
        else $error("brownout bit 7 read nonzero");

    property p_idle_sel;
        @(posedge clk_i) disable iff (!nrst_i)
        events_i.sleep_instr |-> (enter_idle_o != enter_sleep_o) && (enter_idle_o == misc_q[4]);
    endproperty
    a_idle_sel: assert property (p_idle_sel)
        else $error("sleep mode choice wrong");

    property p_irq_gate;
        @(posedge clk_i) disable iff (!nrst_i)
        (brownout_irq_o || ext_irq_o) |-> gie_q;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised with global enable off");

    property p_ext_mask;
        @(posedge clk_i) disable iff (!nrst_i)
        !misc_q[3] |-> !ext_irq_o;
    endproperty
    a_ext_mask: assert property (p_ext_mask)
        else $error("external interrupt not masked");

    property p_bank_bit7;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && wr_i && addr_i == 4'h4) |=> (bank_q == ($past(wdata_i) & 8'h7f));
    endproperty
    a_bank_bit7: assert property (p_bank_bit7)
        else $error("bank select write wrong");

    property p_flag_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (bo_flag_q && !(wr_i && addr_i == `SFR_BROWNOUT_OFS && !wdata_i[`BO_IRQ_FLAG_BIT]))
            |=> bo_flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("brownout flag cleared without a write of zero");

    property p_state_read;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && rd_i && addr_i == `SFR_BROWNOUT_OFS) |=> (rdata_o[5] == $past(state_n));
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("detector state bit read wrong");

    property p_gie_on;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && events_i.irq_global_on_instr && !events_i.irq_global_off_instr)
            |=> irq_global_o;
    endproperty
    a_gie_on: assert property (p_gie_on)
        else $error("global enable not set");

    property p_gie_off;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && events_i.irq_global_off_instr) |=> !irq_global_o;
    endproperty
    a_gie_off: assert property (p_gie_off)
        else $error("global enable not cleared");

    property p_misc_read;
        @(posedge clk_i) disable iff (!nrst_i)
        (clk_en_i && rd_i && addr_i == `SFR_MISC_OFS) |=> (rdata_o[7:6] == 2'b00);
    endproperty
    a_misc_read: assert property (p_misc_read)
        else $error("misc upper bits read nonzero");

    property p_irq_pin_oe;
        @(posedge clk_i) disable iff (!nrst_i)
        misc_q[3] |-> !port5_oe_o[2];
    endproperty
    a_irq_pin_oe: assert property (p_irq_pin_oe)
        else $error("interrupt pin driven while selected");

    property p_analog_oe;
        @(posedge clk_i) disable iff (!nrst_i)
        (port5_oe_o[6:0] & analog_en_o) == 7'h00;
    endproperty
    a_analog_oe: assert property (p_analog_oe)
        else $error("analog pin driven");
endmodule : mcu_special_function_regs

// ---- tb_mcu_special_function_regs.sv ----
// self-checking testbench of the special-function register bank
`timescale 1ns/100ps
`include "sfr_defines.svh"
module tb_mcu_special_function_regs;
    logic                  clk_i;
    logic                  nrst_i;
    logic                  clk_en_i;
    logic [3:0]            addr_i;
    logic [7:0]            wdata_i;
    logic                  wr_i;
    logic                  rd_i;
    logic [7:0]            rdata_o;
    sfr_pkg::core_events_t events_i;
    logic                  alu_update_i;
    sfr_pkg::alu_flags_t   alu_flags_i;
    logic                  below_level_i;
    logic [7:0]            port5_pins_i;
    logic [7:0]            port5_dir_i;
    logic [7:0]            port5_out_o;
    logic [7:0]            port5_oe_o;
    logic [6:0]            analog_en_o;
    logic [5:0]            indirect_addr_o;
    logic                  data_bank_o;
    sfr_pkg::bo_level_t    brownout_level_sel_o;
    logic                  brownout_detector_on_o;
    sfr_pkg::misc_ctrl_t   misc_ctrl_o;
    logic                  main_osc_run_o;
    logic                  enter_idle_o;
    logic                  enter_sleep_o;
    logic                  brownout_irq_o;
    logic                  ext_irq_o;
    logic                  brownout_wake_o;
    logic                  irq_global_o;
    int                    num_errors;
    int                    tests_run;

    mcu_special_function_regs dut (.clk_i(clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .events_i(events_i), .alu_update_i(alu_update_i), .alu_flags_i(alu_flags_i),
        .below_level_i(below_level_i), .port5_pins_i(port5_pins_i),
        .port5_dir_i(port5_dir_i), .port5_out_o(port5_out_o), .port5_oe_o(port5_oe_o),
        .analog_en_o(analog_en_o), .indirect_addr_o(indirect_addr_o),
        .data_bank_o(data_bank_o), .brownout_level_sel_o(brownout_level_sel_o),
        .brownout_detector_on_o(brownout_detector_on_o), .misc_ctrl_o(misc_ctrl_o),
        .main_osc_run_o(main_osc_run_o), .enter_idle_o(enter_idle_o),
        .enter_sleep_o(enter_sleep_o), .brownout_irq_o(brownout_irq_o),
        .ext_irq_o(ext_irq_o), .brownout_wake_o(brownout_wake_o),
        .irq_global_o(irq_global_o));

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic results;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        // one more edge so callers see the written value on the outputs
        @(posedge clk_i);
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask : rd

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk8(v, exp);
    endtask : rdchk

    // one-cycle event pulse; the sleep-mode outputs are looked at while it stands
    task automatic ev(input sfr_pkg::core_events_t e, input logic idl, input logic slp);
        @(posedge clk_i);
        events_i <= e;
        @(posedge clk_i);
        events_i <= '0;
        chk1(enter_idle_o, idl);
        chk1(enter_sleep_o, slp);
        @(posedge clk_i);
    endtask : ev

    initial
    begin
        #200000;
        num_errors++;
        results();
    end

    initial
    begin
        num_errors = 0;
        tests_run = 0;
        nrst_i = 1'b0;
        clk_en_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        events_i = '0;
        alu_update_i = 1'b0;
        alu_flags_i = '0;
        below_level_i = 1'b0;
        port5_pins_i = 8'h00;
        port5_dir_i = 8'h00;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        rdchk(`SFR_STATUS_OFS, 8'h18);
        rdchk(`SFR_BROWNOUT_OFS, 8'h20);
        rdchk(`SFR_MISC_OFS, 8'h20);
        rdchk(4'h0, 8'h00);
        wr(`SFR_STATUS_OFS, 8'hff);
        rdchk(`SFR_STATUS_OFS, 8'h5f);
        wr(`SFR_STATUS_OFS, 8'h00);
        rdchk(`SFR_STATUS_OFS, 8'h18);
        ev(5'b00100, 1'b0, 1'b0);
        rdchk(`SFR_STATUS_OFS, 8'h08);
        ev(5'b10000, 1'b0, 1'b1);
        rdchk(`SFR_STATUS_OFS, 8'h10);
        ev(5'b01000, 1'b0, 1'b0);
        rdchk(`SFR_STATUS_OFS, 8'h18);
        @(posedge clk_i);
        alu_update_i <= 1'b1;
        alu_flags_i <= 3'b101;
        @(posedge clk_i);
        alu_update_i <= 1'b0;
        rdchk(`SFR_STATUS_OFS, 8'h1d);
        wr(`SFR_BANK_OFS, 8'hff);
        rdchk(`SFR_BANK_OFS, 8'h7f);
        chk8({2'b00, indirect_addr_o}, 8'h3f);
        chk1(data_bank_o, 1'b1);
        wr(`SFR_BANK_OFS, 8'h15);
        chk8({data_bank_o, 1'b0, indirect_addr_o}, 8'h15);
        for (int i = 0; i < 4; i++)
        begin
            wr(`SFR_BROWNOUT_OFS, 8'(i));
            chk8({6'h00, brownout_level_sel_o}, 8'(i));
        end
        // writing one to the flag position must not set it
        wr(`SFR_BROWNOUT_OFS, 8'hff);
        rdchk(`SFR_BROWNOUT_OFS, 8'h3f);
        chk1(brownout_detector_on_o, 1'b1);
        ev(5'b00010, 1'b0, 1'b0);
        chk1(irq_global_o, 1'b1);
        chk1(brownout_irq_o, 1'b0);
        below_level_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rdchk(`SFR_BROWNOUT_OFS, 8'h5f);
        chk1(brownout_irq_o, 1'b1);
        chk1(brownout_wake_o, 1'b1);
        ev(5'b00001, 1'b0, 1'b0);
        chk1(brownout_irq_o, 1'b0);
        chk1(brownout_wake_o, 1'b1);
        wr(`SFR_BROWNOUT_OFS, 8'h17);
        chk1(brownout_wake_o, 1'b0);
        wr(`SFR_BROWNOUT_OFS, 8'h1f);
        rdchk(`SFR_BROWNOUT_OFS, 8'h1f);
        wr(`SFR_BROWNOUT_OFS, 8'h1b);
        rdchk(`SFR_BROWNOUT_OFS, 8'h3b);
        wr(`SFR_MISC_OFS, 8'hff);
        rdchk(`SFR_MISC_OFS, 8'h3f);
        chk8({2'b00, misc_ctrl_o}, 8'h3f);
        ev(5'b10000, 1'b1, 1'b0);
        wr(`SFR_MISC_OFS, 8'h05);
        chk8({2'b00, misc_ctrl_o}, 8'h05);
        chk1(main_osc_run_o, 1'b0);
        wr(`SFR_MISC_OFS, 8'h28);
        chk1(main_osc_run_o, 1'b1);
        ev(5'b00010, 1'b0, 1'b0);
        port5_dir_i <= 8'h04;
        port5_pins_i <= 8'h00;
        repeat (6) @(posedge clk_i);
        chk1(ext_irq_o, 1'b1);
        chk1(port5_oe_o[2], 1'b0);
        port5_pins_i <= 8'h04;
        repeat (6) @(posedge clk_i);
        chk1(ext_irq_o, 1'b0);
        rdchk(`SFR_PORT5_OFS, 8'h04);
        port5_pins_i <= 8'h00;
        wr(`SFR_MISC_OFS, 8'h20);
        repeat (6) @(posedge clk_i);
        chk1(ext_irq_o, 1'b0);
        port5_dir_i <= 8'h00;
        wr(`SFR_PORT5_OFS, 8'ha5);
        rdchk(`SFR_PORT5_OFS, 8'ha5);
        chk8(port5_out_o, 8'ha5);
        port5_dir_i <= 8'hff;
        port5_pins_i <= 8'h3c;
        repeat (6) @(posedge clk_i);
        rdchk(`SFR_PORT5_OFS, 8'h3c);
        port5_dir_i <= 8'h00;
        wr(`SFR_ANALOG_OFS, 8'hff);
        rdchk(`SFR_ANALOG_OFS, 8'h7f);
        chk8(port5_oe_o, 8'h80);
        wr(`SFR_ANALOG_OFS, 8'h01);
        chk8({1'b0, analog_en_o}, 8'h01);
        chk8(port5_oe_o, 8'hfe);
        results();
    end
endmodule : tb_mcu_special_function_regs
